// >>> hdl/irq_transfer_pkg.sv
// types of the interrupt and event transfer unit
// assumes nothing of its surroundings
package irq_transfer_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WAIT = 4'h2,
      ST_XFER = 4'h4,
      ST_VEC = 4'h8
   } ctl_state_t;
   typedef enum logic [1:0] {
      EDGE_NONE = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } edge_mode_t;
endpackage : irq_transfer_pkg

// >>> hdl/irq_transfer_regs.svh
// timing constants and reset values for the interrupt and event transfer unit
// assumes inclusion by bare name from hdl/
`ifndef IRQ_TRANSFER_REGS_SVH
`define IRQ_TRANSFER_REGS_SVH
`define LAT_JC_CYCLES 7
`define LAT_NOJC_CYCLES 11
`define XFER_CYCLES 1
`define RST_PTR 16'h0000
`define RST_CNT 8'h00
`define FIFO_DEPTH_DEF 4
`endif

// >>> hdl/irq_transfer_unit.sv
// interrupt nodes, external request router, event transfer channels
// assumes peripherals give level requests synchronous to ref_clk, cpu acks vectors
// Overview of operation
// - each node picks vectored interrupt or event transfer by a per-node bit
// - vectored service raises a vector request with the node number to the cpu
// - an event transfer steals exactly one cpu cycle, no context switch
// - transfer moves byte or word, then bumps source, destination or both
// - channel counter counts down per transfer, not in continuous mode
// - counter reaching zero raises vectored interrupt of the originating node
// - eight independent transfer channels, each triggered by a node request
// - vector entry no earlier than 7 cycles, or 11 without jump cache
// - 64 nodes, each with request flag, enable flag and priority field
// - shared nodes take their source from source select registers
// - router takes peripheral and pin requests before the nodes
// - router has 4 input channels, a routing matrix and 4 output gates
// - edge trigger stage detects rising, falling or both edges
// - output gate passes or blocks events by pattern match or miss
// - hardware trap branches to its handler ahead of any interrupt
`timescale 1ns/100ps
`include "irq_transfer_regs.svh"
module irq_transfer_unit #(
   parameter int NODES = 64,
   parameter int CHANS = 8,
   parameter int ROUTES = 4,
   parameter int SHARED = 4,
   parameter int PRIO_W = 4,
   parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [NODES-1:0] node_src,
   input wire logic [NODES-1:0] node_enable,
   input wire logic [NODES-1:0] node_use_xfer,
   input wire logic [NODES*PRIO_W-1:0] node_prio,
   input wire logic [NODES*3-1:0] node_chan,
   input wire logic [NODES-1:0] node_flag_clr,
   output logic [NODES-1:0] node_flag,
   input wire logic [SHARED*4-1:0] alt_src,
   input wire logic [SHARED*2-1:0] source_select_register,
   input wire logic [ROUTES-1:0] router_in,
   input wire logic [ROUTES*2-1:0] edge_mode,
   input wire logic [ROUTES*ROUTES-1:0] route_matrix,
   input wire logic [ROUTES-1:0] gate_pattern_in,
   input wire logic [ROUTES-1:0] gate_pattern,
   input wire logic [ROUTES-1:0] gate_on_miss,
   output logic [ROUTES-1:0] router_out,
   input wire logic [CHANS-1:0] chan_word,
   input wire logic [CHANS-1:0] chan_inc_src,
   input wire logic [CHANS-1:0] chan_inc_dst,
   input wire logic [CHANS-1:0] chan_continuous,
   input wire logic [CHANS-1:0] chan_load,
   input wire logic [CHANS*16-1:0] chan_load_src,
   input wire logic [CHANS*16-1:0] chan_load_dst,
   input wire logic [CHANS*8-1:0] chan_load_cnt,
   output logic [CHANS*8-1:0] chan_cnt,
   input wire logic jump_cache,
   input wire logic trap_req,
   input wire logic [3:0] trap_class,
   output logic vec_req,
   output logic [6:0] vec_num,
   output logic vec_is_trap,
   input wire logic vec_ack,
   output logic cpu_stall,
   output logic xfer_valid,
   input wire logic xfer_ready,
   output logic [15:0] xfer_src,
   output logic [15:0] xfer_dst,
   output logic xfer_word,
   output logic [2:0] xfer_chan
);
   localparam int NW = $clog2(NODES);
   localparam int FW = 36;
   typedef struct packed {
      irq_transfer_pkg::ctl_state_t state;
      logic [NODES-1:0] flag;
      logic [NODES-1:0] src_d;
      logic [ROUTES-1:0] rin_d;
      logic [ROUTES-1:0] rout;
      logic [CHANS*16-1:0] sptr;
      logic [CHANS*16-1:0] dptr;
      logic [CHANS*8-1:0] cnt;
      logic [NW-1:0] node;
      logic trap;
      logic [3:0] wait_cnt;
      logic [6:0] vnum;
      logic xv;
      logic [15:0] xs;
      logic [15:0] xd;
      logic xw;
      logic [2:0] xc;
   } ctl_t;
   ctl_t st_reg;
   ctl_t st_next;
   logic [NODES-1:0] src_eff;
   logic [ROUTES-1:0] edge_ev;
   logic [ROUTES-1:0] gate_sum;
   logic [NODES-1:0] pend;
   logic any_pend;
   logic [NW-1:0] win;
   logic [PRIO_W-1:0] win_prio;
   logic fifo_in_ready;
   logic [FW-1:0] fifo_out;
   logic [3:0] lat_need;
   assign node_flag = st_reg.flag;
   assign router_out = st_reg.rout;
   assign chan_cnt = st_reg.cnt;
   assign vec_req = st_reg.state == irq_transfer_pkg::ST_VEC;
   assign vec_num = st_reg.vnum;
   assign vec_is_trap = st_reg.trap;
   assign cpu_stall = st_reg.state == irq_transfer_pkg::ST_XFER;
   assign lat_need = jump_cache ? 4'(`LAT_JC_CYCLES) : 4'(`LAT_NOJC_CYCLES);
   // ************************************************************
   // source selection and external request router
   // ************************************************************
   always_comb begin
      src_eff = node_src;
      for (int s = 0; s < SHARED; s++) begin
         src_eff[NODES-SHARED+s] = alt_src[s*4+source_select_register[s*2+:2]];
      end
      for (int r = 0; r < ROUTES; r++) begin
         src_eff[NODES-SHARED-ROUTES+r] = st_reg.rout[r];
      end
   end
   always_comb begin
      for (int r = 0; r < ROUTES; r++) begin
         unique case (irq_transfer_pkg::edge_mode_t'(edge_mode[r*2+:2]))
            irq_transfer_pkg::EDGE_NONE: edge_ev[r] = 1'b0;
            irq_transfer_pkg::EDGE_RISE: edge_ev[r] = router_in[r] && !st_reg.rin_d[r];
            irq_transfer_pkg::EDGE_FALL: edge_ev[r] = !router_in[r] && st_reg.rin_d[r];
            irq_transfer_pkg::EDGE_BOTH: edge_ev[r] = router_in[r] != st_reg.rin_d[r];
         endcase
      end
      for (int g = 0; g < ROUTES; g++) begin
         gate_sum[g] = |(edge_ev & route_matrix[g*ROUTES+:ROUTES]);
         if (gate_on_miss[g]) begin
            gate_sum[g] = gate_sum[g] && (gate_pattern_in != gate_pattern);
         end else begin
            gate_sum[g] = gate_sum[g] && (gate_pattern_in == gate_pattern);
         end
      end
   end
   // ************************************************************
   // priority arbitration
   // ************************************************************
   always_comb begin
      pend = st_reg.flag & node_enable;
      any_pend = |pend;
      win = '0;
      win_prio = '0;
      for (int n = NODES-1; n >= 0; n--) begin
         if (pend[n] && node_prio[n*PRIO_W+:PRIO_W] >= win_prio) begin
            win = NW'(n);
            win_prio = node_prio[n*PRIO_W+:PRIO_W];
         end
      end
   end
   // ************************************************************
   // node flags, channels and service sequencer
   // ************************************************************
   always_comb begin
      logic [2:0] ch;
      logic [7:0] c;
      ch = node_chan[((st_reg.state == irq_transfer_pkg::ST_XFER) ? st_reg.node : win)*3+:3];
      c = st_reg.cnt[ch*8+:8];
      st_next = st_reg;
      st_next.src_d = src_eff;
      st_next.rin_d = router_in;
      st_next.rout = gate_sum;
      st_next.flag = st_reg.flag & ~node_flag_clr;
      for (int k = 0; k < CHANS; k++) begin
         if (chan_load[k]) begin
            st_next.sptr[k*16+:16] = chan_load_src[k*16+:16];
            st_next.dptr[k*16+:16] = chan_load_dst[k*16+:16];
            st_next.cnt[k*8+:8] = chan_load_cnt[k*8+:8];
         end
      end
      if (fifo_in_ready || !st_reg.xv) begin
         st_next.xv = 1'b0;
      end
      unique case (st_reg.state)
         irq_transfer_pkg::ST_IDLE: begin
            st_next.wait_cnt = 4'h1;
            if (trap_req) begin
               st_next.trap = 1'b1;
               st_next.vnum = {3'h0, trap_class};
               st_next.state = irq_transfer_pkg::ST_WAIT;
            end else if (any_pend) begin
               st_next.node = win;
               st_next.trap = 1'b0;
               st_next.vnum = {1'b1, 6'(win)};
               if (node_use_xfer[win] && (c != 8'h00 || chan_continuous[ch])) begin
                  if (fifo_in_ready && !st_reg.xv) begin
                     st_next.state = irq_transfer_pkg::ST_XFER;
                  end
               end else begin
                  st_next.flag[win] = 1'b0;
                  st_next.state = irq_transfer_pkg::ST_WAIT;
               end
            end
         end
         irq_transfer_pkg::ST_XFER: begin
            st_next.flag[st_reg.node] = 1'b0;
            st_next.xv = 1'b1;
            st_next.xs = st_reg.sptr[ch*16+:16];
            st_next.xd = st_reg.dptr[ch*16+:16];
            st_next.xw = chan_word[ch];
            st_next.xc = ch;
            if (chan_inc_src[ch]) begin
               st_next.sptr[ch*16+:16] = st_reg.sptr[ch*16+:16] + (chan_word[ch] ? 16'h2 : 16'h1);
            end
            if (chan_inc_dst[ch]) begin
               st_next.dptr[ch*16+:16] = st_reg.dptr[ch*16+:16] + (chan_word[ch] ? 16'h2 : 16'h1);
            end
            if (!chan_continuous[ch]) begin
               st_next.cnt[ch*8+:8] = c - 8'h01;
            end
            if (!chan_continuous[ch] && c == 8'h01) begin
               st_next.flag[st_reg.node] = 1'b1;
            end
            st_next.state = irq_transfer_pkg::ST_IDLE;
         end
         irq_transfer_pkg::ST_WAIT: begin
            st_next.wait_cnt = st_reg.wait_cnt + 4'h1;
            if (st_reg.wait_cnt >= lat_need - 4'h1) begin
               st_next.state = irq_transfer_pkg::ST_VEC;
            end
         end
         irq_transfer_pkg::ST_VEC: begin
            if (vec_ack) begin
               st_next.state = irq_transfer_pkg::ST_IDLE;
            end
         end
         default: st_next.state = irq_transfer_pkg::ST_IDLE;
      endcase
      for (int n = 0; n < NODES; n++) begin
         if (src_eff[n] && !st_reg.src_d[n]) begin
            st_next.flag[n] = 1'b1;
         end
      end
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
         st_reg.state <= irq_transfer_pkg::ST_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end
   // ************************************************************
   // descriptor buffer toward memory side
   // ************************************************************
   xfer_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .in_valid(st_reg.xv),
      .in_ready(fifo_in_ready),
      .in_data({st_reg.xc, st_reg.xw, st_reg.xs, st_reg.xd}),
      .out_valid(xfer_valid),
      .out_ready(xfer_ready),
      .out_data(fifo_out)
   );
   assign xfer_chan = fifo_out[35:33];
   assign xfer_word = fifo_out[32];
   assign xfer_src = fifo_out[31:16];
   assign xfer_dst = fifo_out[15:0];
endmodule : irq_transfer_unit

// >>> hdl/xfer_fifo.sv
// small fifo holding transfer descriptors on their way to the memory side
// assumes one clock, asynchronous active-high reset
`timescale 1ns/100ps
module xfer_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } fifo_state_t;
   fifo_state_t st_reg;
   fifo_state_t st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;
   assign in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_reg.cnt != '0);
   assign out_data = mem[st_reg.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wr = (st_reg.wr == AW'(DEPTH-1)) ? '0 : st_reg.wr + 1'b1;
      end
      if (pop) begin
         st_next.rd = (st_reg.rd == AW'(DEPTH-1)) ? '0 : st_reg.rd + 1'b1;
      end
      if (push && !pop) begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         st_next.cnt = st_reg.cnt - 1'b1;
      end
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[st_reg.wr] <= in_data;
      end
   end
endmodule : xfer_fifo

// >>> sim/cpu_model.sv
// cpu side model: acknowledges vectors late, takes descriptors unless held
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/100ps
module cpu_model #(parameter int ACK_WAIT = 2) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic vec_req,
   output logic vec_ack = 1'b0,
   input wire logic xfer_valid,
   output logic xfer_ready,
   input wire logic hold
);
   // ****
   // responses
   // ****
   int waited = 0;
   always @(posedge ref_clk or posedge sys_rst) begin
      waited <= (vec_req && !vec_ack && !sys_rst) ? waited + 1 : 0;
      vec_ack <= vec_req && !vec_ack && !sys_rst && waited >= ACK_WAIT;
   end
   assign xfer_ready = xfer_valid && !hold;
endmodule : cpu_model

// >>> sim/irq_checker_sva.sv
// assertions on the cpu side of the interrupt and event transfer unit
// assumes a bind to irq_transfer_unit, one clock, active-high reset
`timescale 1ns/100ps
module irq_checker (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic jump_cache,
   input wire logic trap_req,
   input wire logic vec_req,
   input wire logic [6:0] vec_num,
   input wire logic vec_is_trap,
   input wire logic vec_ack,
   input wire logic cpu_stall,
   input wire logic xfer_valid,
   input wire logic xfer_ready,
   input wire logic [15:0] xfer_src
);
   // ****
   // cpu side
   // ****
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   vec_hold_a: assert property (vec_req && !vec_ack |=> vec_req && $stable(vec_num))
      else $error("vector lost");
   ack_drop_a: assert property (vec_req && vec_ack |=> !vec_req) else $error("kept");
   node_code_a: assert property (vec_req && !vec_is_trap |-> vec_num[6]) else $error("c");
   trap_code_a: assert property (vec_req && vec_is_trap |-> vec_num[6:4] == 3'h0)
      else $error("trap code");
   stall_one_a: assert property (cpu_stall |=> !cpu_stall) else $error("stall");
   stall_desc_a: assert property (cpu_stall |-> ##[1:2] xfer_valid) else $error("d");
   desc_hold_a: assert property (xfer_valid && !xfer_ready |=> $stable(xfer_src))
      else $error("desc changed");
   trap_lat_a: assert property (
      $rose(trap_req) && jump_cache && !vec_req |-> !vec_req [*7] ##[1:3] vec_req)
      else $error("latency");
endmodule : irq_checker

// >>> sim/tb.sv
// bench of the interrupt and event transfer unit with a cpu side model
// assumes cpu_model and irq_checker compiled first
`timescale 1ns/100ps
`define CHK(n, e, s) begin logic [63:0] got; got = s; checks++; if (got !== (e)) begin \
   err_count++; $display("[ERR] %s exp %0h got %0h", n, e, got); end end
module tb;
   // ****
   // stimulus and checks
   // ****
   logic ref_clk = 1'b0, sys_rst = 1'b1, jump_cache = 1'b1, trap_req = 1'b0, hold = 1'b0;
   logic vec_ack, cpu_stall, vec_req, vec_is_trap, xfer_valid, xfer_ready, xfer_word;
   logic [63:0] node_src = '0, node_enable = '0, node_use_xfer = '0, node_flag_clr = '0;
   logic [63:0] node_flag, chan_load_cnt = '0, chan_cnt;
   logic [255:0] node_prio = '0;
   logic [191:0] node_chan = '0;
   logic [127:0] chan_load_src = '0, chan_load_dst = '0;
   logic [15:0] alt_src = '0, route_matrix = 16'h0001, xfer_src, xfer_dst;
   logic [7:0] source_select_register = '0, edge_mode = '0, chan_word = '0, chan_inc_src = '0;
   logic [7:0] chan_inc_dst = '0, chan_continuous = '0, chan_load = '0, vq[$];
   logic [3:0] router_in = '0, gate_pattern_in = '0, gate_pattern = '0, gate_on_miss = '0;
   logic [3:0] router_out, trap_class = '0;
   logic [6:0] vec_num;
   logic [2:0] xfer_chan;
   logic [35:0] xq[$];
   int err_count = 0, checks = 0, stalls = 0, pulses = 0;
   irq_transfer_unit dut_u (
      .ref_clk, .sys_rst, .node_src, .node_enable, .node_use_xfer, .node_prio, .node_chan,
      .node_flag_clr, .node_flag, .alt_src, .source_select_register, .router_in, .edge_mode,
      .route_matrix, .gate_pattern_in, .gate_pattern, .gate_on_miss, .router_out, .chan_word,
      .chan_inc_src, .chan_inc_dst, .chan_continuous, .chan_load, .chan_load_src,
      .chan_load_dst, .chan_load_cnt, .chan_cnt, .jump_cache, .trap_req, .trap_class, .vec_req,
      .vec_num, .vec_is_trap, .vec_ack, .cpu_stall, .xfer_valid, .xfer_ready, .xfer_src,
      .xfer_dst, .xfer_word, .xfer_chan);
   cpu_model cpu_u (.ref_clk, .sys_rst, .vec_req, .vec_ack, .xfer_valid, .xfer_ready, .hold);
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      stalls <= stalls + int'(cpu_stall);
      pulses <= pulses + int'(router_out[0]);
      if (xfer_valid && xfer_ready) xq.push_back({xfer_chan, xfer_word, xfer_src, xfer_dst});
      if (vec_req && vec_ack) vq.push_back({vec_is_trap, vec_num});
   end
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic await_q(int nv, int nx);
      int i;
      for (i = 0; i < 300 && (vq.size() < nv || xq.size() < nx); i++) tick(1);
      if (i == 300) begin
         err_count++;
         $display("[ERR] wait exp done got timeout");
         end_sim();
      end
   endtask : await_q
   task automatic req(int n);
      node_src[n] = 1'b1;
      tick(2);
      node_src[n] = 1'b0;
      tick(6);
   endtask : req
   task automatic trap_lat(logic jc, int lat);
      int n;
      jump_cache = jc;
      trap_class = 4'h5;
      trap_req = 1'b1;
      for (n = 0; n < 20 && vec_req !== 1'b1; n++) tick(1);
      trap_req = 1'b0;
      await_q(1, 0);
      `CHK("latency", lat, n)
      `CHK("trap_vec", 8'h85, vq.pop_front())
   endtask : trap_lat
   task automatic prio_order();
      node_prio[31:12] = 20'h90902;
      node_enable[7:3] = 5'h15;
      node_src[8:3] = 6'h35;
      tick(2);
      node_src[8:3] = 6'h00;
      await_q(3, 0);
      `CHK("high", 8'h45, vq.pop_front())
      `CHK("tie", 8'h47, vq.pop_front())
      `CHK("low", 8'h43, vq.pop_front())
      `CHK("masked", 1'b1, node_flag[8])
      node_flag_clr[8] = 1'b1;
      tick(1);
      node_flag_clr[8] = 1'b0;
      `CHK("cleared", 1'b0, node_flag[8])
   endtask : prio_order
   task automatic xfer_fill();
      int s0;
      node_enable[11:10] = 2'h3;
      node_use_xfer[11:10] = 2'h3;
      node_chan[35:30] = 6'h22;
      chan_word = 8'h04;
      chan_inc_src = 8'h14;
      chan_inc_dst = 8'h10;
      chan_continuous = 8'h10;
      chan_load_src[79:32] = 48'h3000_0000_1000;
      chan_load_dst[79:32] = 48'h4000_0000_2000;
      chan_load_cnt[39:16] = 24'h010005;
      chan_load = 8'h14;
      tick(1);
      chan_load = 8'h00;
      hold = 1'b1;
      s0 = stalls;
      repeat (5) req(10);
      `CHK("full", 4, stalls - s0)
      `CHK("cnt", 8'h01, chan_cnt[23:16])
      hold = 1'b0;
      await_q(1, 5);
      `CHK("first", 36'h510002000, xq[0])
      `CHK("last", 36'h510082000, xq[4])
      `CHK("zero_vec", 8'h4A, vq.pop_front())
      xq.delete();
   endtask : xfer_fill
   task automatic xfer_cont();
      req(11);
      req(11);
      await_q(0, 2);
      `CHK("byte_step", 36'h830014001, xq[1])
      `CHK("cont_cnt", 8'h01, chan_cnt[39:32])
      `CHK("other", 8'h00, chan_cnt[23:16])
      `CHK("no_vec", 0, vq.size())
   endtask : xfer_cont
   task automatic router_edges();
      int p0;
      for (int i = 0; i < 6; i++) begin
         edge_mode[1:0] = (i < 4) ? 2'(i) : 2'h1;
         gate_pattern[0] = i > 3;
         gate_on_miss[0] = i == 5;
         p0 = pulses;
         router_in[0] = 1'b1;
         tick(4);
         router_in[0] = 1'b0;
         tick(4);
         `CHK("events", (i == 3) ? 2 : int'(i % 4 != 0), pulses - p0)
      end
   endtask : router_edges
   task automatic end_sim();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   initial begin
      tick(4);
      sys_rst = 1'b0;
      tick(2);
      trap_lat(1'b1, 7);
      trap_lat(1'b0, 11);
      prio_order();
      xfer_fill();
      xfer_cont();
      router_edges();
      end_sim();
   end
endmodule : tb
bind irq_transfer_unit irq_checker chk_u (.ref_clk, .sys_rst, .jump_cache, .trap_req, .vec_req,
   .vec_num, .vec_is_trap, .vec_ack, .cpu_stall, .xfer_valid, .xfer_ready, .xfer_src);
